//--- core/brsma_defines.svh
`ifndef BRSMA_DEFINES_SVH
`define BRSMA_DEFINES_SVH

// reset values
`define BRSMA_ACC_RST     32'h0000_0000
`define BRSMA_FLAGS_RST   9'h000
// bcd layout
`define BRSMA_DIGITS      8
`define BRSMA_MUL_DIGITS  3'h4
// ieee single layout
`define BRSMA_SIGN_BIT    31
`define BRSMA_EXP_MSB     30
`define BRSMA_EXP_LSB     23
`define BRSMA_EXP_ALL1    8'hff
// addend this many times smaller is lost (2**24)
`define BRSMA_PREC_RATIO  16777216
// alignment shift at which the smaller mantissa is gone (24 bits + 1)
`define BRSMA_ALIGN_LIM   8'h19
`endif

//--- core/brsma_pkg.sv
package brsma_pkg;

  // operations issued by the sequencer
  typedef enum logic [2:0] {
    OP_BCD_SUBTRACT_WORD   = 3'h0,
    OP_BCD_SUBTRACT_DOUBLE = 3'h1,
    OP_REAL_SUBTRACT       = 3'h2,
    OP_REAL_ADD            = 3'h3,
    OP_BCD_MULTIPLY_WORD   = 3'h4,
    OP_LOAD                = 3'h5
  } brsma_op_e;

  // multiply sequencer, gray along idle-shift-add
  typedef enum logic [1:0] {
    BRSMA_ST_IDLE  = 2'h0,
    BRSMA_ST_SHIFT = 2'h1,
    BRSMA_ST_ADD   = 2'h3
  } brsma_st_e;

  typedef logic [31:0] brsma_word_t;

  // status flags as seen by the sequencer
  typedef struct packed {
    logic zero;
    logic borrow16;
    logic borrow32;
    logic negative;
    logic invalid_pointer;
    logic valid_float;
    logic sign_error;
    logic underflow;
    logic bad_operand;
  } brsma_flags_s;

  // true when every nibble is a decimal digit
  function automatic logic brsma_is_bcd(input brsma_word_t w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (w[4*i +: 4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction : brsma_is_bcd

endpackage : brsma_pkg

//--- core/brsma_bcd_if.sv
`timescale 1ns/1ps
interface brsma_bcd_if;
  import brsma_pkg::*;
  brsma_word_t a;         // minuend or augend
  brsma_word_t b;         // subtrahend or addend
  logic        sub;       // high subtracts
  brsma_word_t res;       // decimal result
  logic        lo_carry;  // carry or borrow out of digit 3
  logic        hi_carry;  // carry or borrow out of digit 7
  modport user (output a, b, sub, input res, lo_carry, hi_carry);
  modport unit (input a, b, sub, output res, lo_carry, hi_carry);
endinterface : brsma_bcd_if

//--- core/brsma_bcd_addsub.sv
`timescale 1ns/1ps
module brsma_bcd_addsub #(
  parameter int DIGITS = 8
) (
  brsma_bcd_if.unit bus
);
  import brsma_pkg::*;

  logic [DIGITS:0] cy;  // digit carry / borrow chain
  assign cy[0] = 1'b0;

  // one decimal digit cell per nibble
  for (genvar g = 0; g < DIGITS; g++) begin : g_digit
    logic [4:0] raw;  // binary digit sum or difference
    logic [4:0] fix;  // decimal corrected digit
    logic       co;   // carry or borrow to the next digit
    always_comb begin
      if (bus.sub) begin
        raw = {1'b0, bus.a[4*g +: 4]} - {1'b0, bus.b[4*g +: 4]} - {4'h0, cy[g]};
        // negative digit wraps, adding ten restores it modulo sixteen
        co  = raw[4];
        fix = co ? raw + 5'h0a : raw;
      end else begin
        raw = {1'b0, bus.a[4*g +: 4]} + {1'b0, bus.b[4*g +: 4]} + {4'h0, cy[g]};
        co  = raw > 5'h09;
        fix = co ? raw - 5'h0a : raw;
      end
    end
    assign cy[g+1]              = co;
    assign bus.res[4*g +: 4]    = fix[3:0];
  end

  assign bus.lo_carry = cy[4];
  assign bus.hi_carry = cy[DIGITS];

endmodule : brsma_bcd_addsub

//--- core/brsma_alu.sv
`timescale 1ns/1ps
`include "brsma_defines.svh"
module brsma_alu (
  input  logic                  clk,                   // 200 MHz core clock
  input  logic                  sys_rst,               // async, active high
  input  logic                  clk_en,                // low freezes all state
  input  logic                  op_valid,              // sequencer issues an op
  input  brsma_pkg::brsma_op_e  op_code,               // operation
  input  brsma_pkg::brsma_word_t op_operand,           // memory word(s) or constant
  input  logic                  op_ptr_bad,            // pointer outside data memory
  output brsma_pkg::brsma_word_t acc,                  // accumulator
  output logic                  busy,                  // multiply in progress
  output logic                  done,                  // op complete, one cycle
  output logic                  zero_flag,
  output logic                  borrow16_flag,
  output logic                  borrow32_flag,
  output logic                  negative_flag,
  output logic                  invalid_pointer_flag,
  output logic                  valid_float_flag,
  output logic                  sign_error_flag,
  output logic                  underflow_flag,
  output logic                  bad_operand_flag
);
  import brsma_pkg::*;

  // architectural state
  brsma_word_t  acc_ff,    nxt_acc;     // accumulator
  brsma_flags_s flags_ff,  nxt_flags;   // status flags
  brsma_st_e    st_ff,     nxt_st;      // multiply sequencer
  brsma_op_e    op_ff,     nxt_op;      // last accepted op
  logic         busy_ff,   nxt_busy;
  logic         done_ff,   nxt_done;
  // multiply working state
  brsma_word_t  prod_ff,   nxt_prod;    // running product
  logic [15:0]  mcand_ff,  nxt_mcand;   // accumulator low half
  logic [15:0]  mplier_ff, nxt_mplier;  // operand digits, top first
  logic [2:0]   dcnt_ff,   nxt_dcnt;    // digits left
  logic [3:0]   rep_ff,    nxt_rep;     // adds left for this digit

  // shared decimal adder
  brsma_bcd_if bcd ();
  brsma_bcd_addsub #(.DIGITS(`BRSMA_DIGITS)) u_bcd (.bus(bcd));

  // operand checks
  logic accept;    // op taken this cycle
  logic is_real;   // op works on reals
  logic ok_word;   // both low halves decimal
  logic ok_dbl;    // both words decimal
  logic fp_ok;     // neither word is inf or nan
  assign accept  = op_valid && clk_en && !busy_ff;
  assign is_real = (op_code == OP_REAL_SUBTRACT) || (op_code == OP_REAL_ADD);
  assign ok_word = brsma_is_bcd({16'h0000, acc_ff[15:0]})
                && brsma_is_bcd({16'h0000, op_operand[15:0]});
  assign ok_dbl  = brsma_is_bcd(acc_ff) && brsma_is_bcd(op_operand);
  assign fp_ok   = (acc_ff[`BRSMA_EXP_MSB:`BRSMA_EXP_LSB] != `BRSMA_EXP_ALL1)
                && (op_operand[`BRSMA_EXP_MSB:`BRSMA_EXP_LSB] != `BRSMA_EXP_ALL1);

  // decimal adder input steering
  always_comb begin
    if (st_ff == BRSMA_ST_ADD) begin
      bcd.a   = prod_ff;                        // product plus multiplicand
      bcd.b   = {16'h0000, mcand_ff};
      bcd.sub = 1'b0;
    end else if (op_code == OP_BCD_SUBTRACT_DOUBLE) begin
      bcd.a   = acc_ff;
      bcd.b   = op_operand;
      bcd.sub = 1'b1;
    end else begin
      bcd.a   = {16'h0000, acc_ff[15:0]};
      bcd.b   = {16'h0000, op_operand[15:0]};
      bcd.sub = 1'b1;
    end
  end

  // real add / subtract, truncating, denormals read as zero
  logic        fs_a, fs_b, fs_big;   // signs
  logic [7:0]  fe_a, fe_b, fe_big;   // exponents
  logic [7:0]  fe_sml, fe_dif;
  logic [23:0] fm_a, fm_b, fm_big;   // mantissas with hidden one
  logic [23:0] fm_sml;
  logic [26:0] fx_sml, fx_sum;       // two guard bits
  logic [26:0] fx_norm;
  logic [9:0]  fx_exp;               // signed room for under/overflow
  logic [4:0]  f_lz;                 // leading zeros from bit 25 down
  brsma_word_t fp_res;
  logic        fp_ovf, fp_unf;
  always_comb begin
    fs_a = acc_ff[`BRSMA_SIGN_BIT];
    fe_a = acc_ff[`BRSMA_EXP_MSB:`BRSMA_EXP_LSB];
    fm_a = (fe_a == 8'h00) ? 24'h000000 : {1'b1, acc_ff[22:0]};
    // subtract flips the operand sign
    fs_b = op_operand[`BRSMA_SIGN_BIT] ^ (op_code == OP_REAL_SUBTRACT);
    fe_b = op_operand[`BRSMA_EXP_MSB:`BRSMA_EXP_LSB];
    fm_b = (fe_b == 8'h00) ? 24'h000000 : {1'b1, op_operand[22:0]};
    // larger magnitude leads and lends its sign
    if ({fe_a, fm_a} >= {fe_b, fm_b}) begin
      fs_big = fs_a; fe_big = fe_a; fm_big = fm_a; fe_sml = fe_b; fm_sml = fm_b;
    end else begin
      fs_big = fs_b; fe_big = fe_b; fm_big = fm_b; fe_sml = fe_a; fm_sml = fm_a;
    end
    fe_dif = fe_big - fe_sml;
    // an addend beyond the mantissa width is dropped
    fx_sml = (fe_dif >= `BRSMA_ALIGN_LIM) ? 27'h0 : ({1'b0, fm_sml, 2'b00} >> fe_dif);
    fx_sum = (fs_a ^ fs_b) ? {1'b0, fm_big, 2'b00} - fx_sml
                           : {1'b0, fm_big, 2'b00} + fx_sml;
    // leading one position, highest set bit wins
    f_lz = 5'h00;
    for (int i = 0; i < 26; i++) begin
      if (fx_sum[i]) f_lz = 5'(25 - i);
    end
    if (fx_sum[26]) begin
      fx_norm = fx_sum >> 1;
      fx_exp  = {2'b00, fe_big} + 10'h001;
    end else begin
      fx_norm = fx_sum << f_lz;
      fx_exp  = {2'b00, fe_big} - {5'h00, f_lz};
    end
    fp_ovf = 1'b0;
    fp_unf = 1'b0;
    if (fx_sum == 27'h0) begin
      fp_res = `BRSMA_ACC_RST;                  // exact cancellation gives +0
    end else if (fx_exp[9] || (fx_exp == 10'h000)) begin
      fp_unf = 1'b1;
      fp_res = {fs_big, 31'h0};
    end else if (fx_exp >= {2'b00, `BRSMA_EXP_ALL1}) begin
      fp_ovf = 1'b1;
      fp_res = {fs_big, `BRSMA_EXP_ALL1, 23'h0};
    end else begin
      fp_res = {fs_big, fx_exp[7:0], fx_norm[24:2]};
    end
  end

  // next state of accumulator, flags and multiply sequencer
  logic        fin;       // op completes this cycle
  logic        fin_real;  // completing op was real
  brsma_word_t fin_acc;   // value the accumulator takes
  always_comb begin
    nxt_acc    = acc_ff;
    nxt_flags  = flags_ff;
    nxt_st     = st_ff;
    nxt_op     = op_ff;
    nxt_busy   = busy_ff;
    nxt_done   = 1'b0;
    nxt_prod   = prod_ff;
    nxt_mcand  = mcand_ff;
    nxt_mplier = mplier_ff;
    nxt_dcnt   = dcnt_ff;
    nxt_rep    = rep_ff;
    fin        = 1'b0;
    fin_real   = 1'b0;
    fin_acc    = acc_ff;
    unique case (st_ff)
      BRSMA_ST_IDLE: begin
        if (accept) begin
          nxt_op   = op_code;
          fin      = 1'b1;
          fin_real = is_real;
          nxt_flags.invalid_pointer = op_ptr_bad;
          // a bad pointer leaves the accumulator alone
          if (!op_ptr_bad) begin
            unique case (op_code)
              OP_BCD_SUBTRACT_WORD: begin
                nxt_flags.bad_operand = !ok_word;
                if (ok_word) begin
                  fin_acc            = bcd.res;
                  nxt_flags.borrow16 = bcd.lo_carry;
                end
              end
              OP_BCD_SUBTRACT_DOUBLE: begin
                nxt_flags.bad_operand = !ok_dbl;
                if (ok_dbl) begin
                  fin_acc            = bcd.res;
                  nxt_flags.borrow16 = bcd.lo_carry;
                  nxt_flags.borrow32 = bcd.hi_carry;
                end
              end
              OP_REAL_SUBTRACT, OP_REAL_ADD: begin
                nxt_flags.bad_operand = !fp_ok;
                if (fp_ok) begin
                  fin_acc              = fp_res;
                  nxt_flags.sign_error = fp_ovf;
                  nxt_flags.underflow  = fp_unf;
                end
              end
              OP_BCD_MULTIPLY_WORD: begin
                nxt_flags.bad_operand = !ok_word;
                if (ok_word) begin
                  fin        = 1'b0;
                  nxt_busy   = 1'b1;
                  nxt_st     = BRSMA_ST_SHIFT;
                  nxt_mcand  = acc_ff[15:0];
                  nxt_mplier = op_operand[15:0];
                  nxt_prod   = `BRSMA_ACC_RST;
                  nxt_dcnt   = `BRSMA_MUL_DIGITS;
                end
              end
              OP_LOAD: begin
                fin_acc = op_operand;                 // preset accumulator
              end
              default: begin
                fin_acc = acc_ff;                     // unknown op: no change
              end
            endcase
          end
        end
      end
      BRSMA_ST_SHIFT: begin
        if (dcnt_ff == 3'h0) begin
          fin     = 1'b1;                             // product complete
          fin_acc = prod_ff;
        end else begin
          // product times ten, next multiplier digit
          nxt_prod   = {prod_ff[27:0], 4'h0};
          nxt_rep    = mplier_ff[15:12];
          nxt_mplier = {mplier_ff[11:0], 4'h0};
          nxt_dcnt   = dcnt_ff - 3'h1;
          nxt_st     = BRSMA_ST_ADD;
        end
      end
      BRSMA_ST_ADD: begin
        if (rep_ff == 4'h0) begin
          nxt_st = BRSMA_ST_SHIFT;
        end else begin
          nxt_prod = bcd.res;                         // add multiplicand once
          nxt_rep  = rep_ff - 4'h1;
        end
      end
      default: begin
        nxt_st   = BRSMA_ST_IDLE;                     // illegal code recovers
        nxt_busy = 1'b0;
      end
    endcase
    // completion updates accumulator and result flags together
    if (fin) begin
      nxt_acc  = fin_acc;
      nxt_done = 1'b1;
      nxt_busy = 1'b0;
      nxt_st   = BRSMA_ST_IDLE;
      nxt_flags.zero     = fin_real ? (fin_acc[30:0] == 31'h0)
                                    : (fin_acc == `BRSMA_ACC_RST);
      nxt_flags.negative = fin_acc[`BRSMA_SIGN_BIT];
      if (fin_real) begin
        nxt_flags.valid_float =
          fin_acc[`BRSMA_EXP_MSB:`BRSMA_EXP_LSB] != `BRSMA_EXP_ALL1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff    <= `BRSMA_ACC_RST;
      flags_ff  <= `BRSMA_FLAGS_RST;
      st_ff     <= BRSMA_ST_IDLE;
      op_ff     <= OP_LOAD;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      prod_ff   <= `BRSMA_ACC_RST;
      mcand_ff  <= 16'h0000;
      mplier_ff <= 16'h0000;
      dcnt_ff   <= 3'h0;
      rep_ff    <= 4'h0;
    end else if (clk_en) begin
      acc_ff    <= nxt_acc;
      flags_ff  <= nxt_flags;
      st_ff     <= nxt_st;
      op_ff     <= nxt_op;
      busy_ff   <= nxt_busy;
      done_ff   <= nxt_done;
      prod_ff   <= nxt_prod;
      mcand_ff  <= nxt_mcand;
      mplier_ff <= nxt_mplier;
      dcnt_ff   <= nxt_dcnt;
      rep_ff    <= nxt_rep;
    end
  end

  // outputs straight from registers
  assign acc                  = acc_ff;
  assign busy                 = busy_ff;
  assign done                 = done_ff;
  assign zero_flag            = flags_ff.zero;
  assign borrow16_flag        = flags_ff.borrow16;
  assign borrow32_flag        = flags_ff.borrow32;
  assign negative_flag        = flags_ff.negative;
  assign invalid_pointer_flag = flags_ff.invalid_pointer;
  assign valid_float_flag     = flags_ff.valid_float;
  assign sign_error_flag      = flags_ff.sign_error;
  assign underflow_flag       = flags_ff.underflow;
  assign bad_operand_flag     = flags_ff.bad_operand;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_word_zero;
    accept && op_code == OP_BCD_SUBTRACT_WORD && !op_ptr_bad && ok_word
      && op_operand[15:0] == acc_ff[15:0] |=> acc_ff == 32'h0 && flags_ff.zero;
  endproperty
  a_word_zero: assert property (p_word_zero) else $error("word subtract not zero");
  property p_word_borrow;
    accept && op_code == OP_BCD_SUBTRACT_WORD && !op_ptr_bad && ok_word |=> done_ff
      && flags_ff.borrow16 == ($past(op_operand[15:0]) > $past(acc_ff[15:0]));
  endproperty
  a_word_borrow: assert property (p_word_borrow) else $error("borrow16 wrong");
  property p_dbl_borrow;
    accept && op_code == OP_BCD_SUBTRACT_DOUBLE && !op_ptr_bad && ok_dbl
      |=> flags_ff.borrow32 == ($past(op_operand) > $past(acc_ff));
  endproperty
  a_dbl_borrow: assert property (p_dbl_borrow) else $error("borrow32 wrong");
  property p_real_self;
    accept && op_code == OP_REAL_SUBTRACT && !op_ptr_bad && fp_ok && op_operand == acc_ff
      |=> acc_ff[30:0] == 31'h0 && flags_ff.zero;
  endproperty
  a_real_self: assert property (p_real_self) else $error("x minus x not zero");
  property p_tiny_add;
    accept && op_code == OP_REAL_ADD && !op_ptr_bad && fp_ok && fe_b != 8'h00
      && {1'b0, fe_a} >= {1'b0, fe_b} + 9'h019 |=> acc_ff == $past(acc_ff);
  endproperty
  a_tiny_add: assert property (p_tiny_add) else $error("tiny addend changed acc");
  property p_mul_zero;
    accept && op_code == OP_BCD_MULTIPLY_WORD && !op_ptr_bad && ok_word
      && op_operand[15:0] == 16'h0 |-> ##[9:60] (done_ff && acc_ff == 32'h0);
  endproperty
  a_mul_zero: assert property (p_mul_zero) else $error("times zero not zero");
  property p_negative;
    done_ff |-> flags_ff.negative == acc_ff[31];
  endproperty
  a_negative: assert property (p_negative) else $error("negative flag wrong");
  property p_bad_bcd;
    accept && op_code == OP_BCD_SUBTRACT_DOUBLE && !op_ptr_bad && !ok_dbl
      |=> flags_ff.bad_operand && acc_ff == $past(acc_ff);
  endproperty
  a_bad_bcd: assert property (p_bad_bcd) else $error("bad digit missed");
  property p_ptr;
    accept && op_ptr_bad |=> flags_ff.invalid_pointer && acc_ff == $past(acc_ff);
  endproperty
  a_ptr: assert property (p_ptr) else $error("bad pointer missed");
  property p_vfloat;
    done_ff && (op_ff == OP_REAL_ADD || op_ff == OP_REAL_SUBTRACT)
      |-> flags_ff.valid_float == (acc_ff[30:23] != 8'hff);
  endproperty
  a_vfloat: assert property (p_vfloat) else $error("valid float wrong");
  property p_nonreal;
    accept && is_real && !op_ptr_bad && !fp_ok |=> flags_ff.bad_operand
      && (flags_ff.zero == ($past(acc_ff[30:0]) == 31'h0)) && acc_ff == $past(acc_ff);
  endproperty
  a_nonreal: assert property (p_nonreal) else $error("non-real missed");

  c_mul: cover property (accept && op_code == OP_BCD_MULTIPLY_WORD ##[9:60] done_ff);
  c_borrow: cover property (done_ff && flags_ff.borrow16);
  c_unf: cover property (done_ff && flags_ff.underflow);

endmodule : brsma_alu

//--- test/brsma_seq_model.sv
`timescale 1ns/1ps
// stand-in for the instruction sequencer on the far side of the alu
module brsma_seq_model (
  input  logic                   clk,
  input  logic                   clk_en,
  input  logic                   busy,
  output logic                   op_valid,
  output brsma_pkg::brsma_op_e   op_code,
  output brsma_pkg::brsma_word_t op_operand,
  output logic                   op_ptr_bad
);
  import brsma_pkg::*;
  // quiet request lines from time zero
  initial begin
    op_valid   = 1'b0;
    op_code    = OP_LOAD;
    op_operand = 32'h0;
    op_ptr_bad = 1'b0;
  end
  // present one op, hold it, return on the edge that takes it
  task automatic issue(input brsma_op_e c, input brsma_word_t v, input logic pb);
    logic ok;
    op_valid   <= 1'b1;
    op_code    <= c;
    op_operand <= v;
    op_ptr_bad <= pb;
    do begin
      @(negedge clk);
      ok = (busy === 1'b0) && (clk_en === 1'b1);
      @(posedge clk);
    end while (!ok);
  endtask : issue
  // slow sequencer: drop the request, operand lines no longer hold
  task automatic idle(input int n);
    op_valid   <= 1'b0;
    op_operand <= ~op_operand;
    op_ptr_bad <= ~op_ptr_bad;
    repeat (n) @(posedge clk);
  endtask : idle
endmodule : brsma_seq_model

//--- test/bcd_real_subtract_multiply_alu_tb.sv
`timescale 1ns/1ps
module bcd_real_subtract_multiply_alu_tb;
  import brsma_pkg::*;
  localparam longint DEC8 = 64'h5f5_e100;  // ten to the eighth
  localparam longint DEC4 = 64'h2710;      // ten to the fourth
  typedef struct {logic [31:0] r; logic [8:0] f; logic [8:0] m;} brsma_note_s;
  typedef struct {brsma_op_e c; logic [31:0] v; logic [31:0] r; logic [8:0] f; logic [8:0] m;} brsma_row_s;
  logic        clk, sys_rst, clk_en, op_valid, op_ptr_bad, busy, done;
  brsma_op_e   op_code;
  brsma_word_t op_operand, acc, exp_acc;
  logic [8:0]  fl;                  // flags, zero in bit 8
  logic [15:0] seed;                // lfsr state
  int          err_total, check_count;
  brsma_note_s q[$];                // notes of expected results
  brsma_note_s nt;
  brsma_row_s  rows [13];           // real op table
  brsma_alu i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_operand(op_operand), .op_ptr_bad(op_ptr_bad), .acc(acc),
    .busy(busy), .done(done), .zero_flag(fl[8]), .borrow16_flag(fl[7]),
    .borrow32_flag(fl[6]), .negative_flag(fl[5]), .invalid_pointer_flag(fl[4]),
    .valid_float_flag(fl[3]), .sign_error_flag(fl[2]), .underflow_flag(fl[1]),
    .bad_operand_flag(fl[0]));
  brsma_seq_model i_seq (.clk(clk), .clk_en(clk_en), .busy(busy), .op_valid(op_valid),
    .op_code(op_code), .op_operand(op_operand), .op_ptr_bad(op_ptr_bad));
  // 200 mhz clock
  always #2.5 clk = ~clk;
  // bcd helpers
  function automatic brsma_word_t i2b(input longint v);
    brsma_word_t w;
    longint      x;
    x = v % DEC8;
    for (int i = 0; i < 8; i++) begin
      w[4*i +: 4] = 4'(x % 64'ha);
      x = x / 64'ha;
    end
    return w;
  endfunction : i2b
  function automatic longint b2i(input brsma_word_t w);
    longint x;
    x = 0;
    for (int i = 7; i >= 0; i--) x = x * 64'ha + longint'(w[4*i +: 4]);
    return x;
  endfunction : b2i
  function automatic logic [15:0] nxt_rnd(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt_rnd
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // note the expectation, then let the sequencer issue
  task automatic run(input brsma_op_e c, input brsma_word_t v, input logic pb,
                     input brsma_word_t r, input logic [8:0] f, input logic [8:0] m);
    q.push_back('{r, f, m});
    exp_acc = r;
    i_seq.issue(c, v, pb);
    seed = nxt_rnd(seed);
    if (seed[0]) i_seq.idle(1 + seed[2:1]);
  endtask : run
  // decimal ops and load, expectations from the bcd arithmetic
  task automatic bop(input brsma_op_e c, input brsma_word_t v);
    longint a, b;
    logic [8:0] f, m;
    brsma_word_t w;
    a = b2i(c == OP_BCD_SUBTRACT_DOUBLE ? exp_acc : {16'h0, exp_acc[15:0]});
    b = b2i(c == OP_BCD_SUBTRACT_DOUBLE ? v : {16'h0, v[15:0]});
    f = 9'h0;
    m = 9'h131;                                          // zero, neg, pointer, bad digit
    if (c == OP_LOAD) begin
      w = v;
      m = 9'h130;
    end else if (c == OP_BCD_MULTIPLY_WORD) w = i2b(a * b);
    else begin
      w = i2b(a - b + DEC8);
      f[7] = (a % DEC4) < (b % DEC4);
      m[7] = 1'b1;
      f[6] = a < b;
      m[6] = (c == OP_BCD_SUBTRACT_DOUBLE);
    end
    f[8] = (w == 32'h0);
    f[5] = w[31];
    run(c, v, 1'b0, w, f, m);
  endtask : bop
  // refused op: accumulator kept, error, zero and negative flags known
  task automatic bad(input brsma_op_e c, input brsma_word_t v, input logic pb, input logic [8:0] f,
                     input logic [8:0] m);
    run(c, v, pb, exp_acc, f | {exp_acc == 32'h0, 2'h0, exp_acc[31], 5'h0}, m);
  endtask : bad
  // result watcher, flags read in the done cycle before any later update
  always @(posedge clk) begin
    if (sys_rst === 1'b0 && clk_en === 1'b1 && done === 1'b1) begin
      if (q.size() == 0) chk("spare done", 32'h1, 32'h0);
      else begin
        nt = q.pop_front();
        chk("acc", acc, nt.r);
        chk("flags", 32'(fl & nt.m), 32'(nt.f & nt.m));
        chk("busy", 32'(busy), 32'h0);
      end
    end
  end
  // hang guard
  initial begin
    #60000;
    err_total++;
    give_verdict();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    err_total = 0;
    check_count = 0;
    exp_acc = 32'h0;
    seed = 16'h1ad4;
    rows = '{'{OP_LOAD, 32'h3f80_0000, 32'h0, 9'h0, 9'h0},
      '{OP_REAL_ADD, 32'h3f80_0000, 32'h4000_0000, 9'h008, 9'h13f},       // 1 + 1
      '{OP_REAL_SUBTRACT, 32'h3f80_0000, 32'h3f80_0000, 9'h008, 9'h13f},  // 2 - 1
      '{OP_REAL_SUBTRACT, 32'h3f80_0000, 32'h0, 9'h108, 9'h13f},          // 1 - 1
      '{OP_LOAD, 32'h4b80_0000, 32'h0, 9'h0, 9'h0},
      '{OP_REAL_ADD, 32'h3f00_0000, 32'h4b80_0000, 9'h008, 9'h13f},       // addend lost
      '{OP_LOAD, 32'h7f7f_ffff, 32'h0, 9'h0, 9'h0},
      '{OP_REAL_ADD, 32'h7f7f_ffff, 32'h7f80_0000, 9'h004, 9'h13f},       // overflow
      '{OP_LOAD, 32'h00c0_0000, 32'h0, 9'h0, 9'h0},
      '{OP_REAL_SUBTRACT, 32'h0080_0000, 32'h0, 9'h10a, 9'h13f},          // underflow
      '{OP_LOAD, 32'hc000_0000, 32'h0, 9'h0, 9'h0},
      '{OP_REAL_SUBTRACT, 32'h3f80_0000, 32'hc040_0000, 9'h028, 9'h13f},  // negative
      '{OP_REAL_SUBTRACT, 32'h7f80_0000, 32'hc040_0000, 9'h029, 9'h139}}; // non-real
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bop(OP_LOAD, 32'h5);
    bop(OP_BCD_SUBTRACT_WORD, 32'h7);
    bop(OP_LOAD, 32'h9999_9999);
    bop(OP_BCD_SUBTRACT_DOUBLE, 32'h9999_9999);
    bop(OP_BCD_SUBTRACT_DOUBLE, 32'h1);
    bop(OP_LOAD, 32'h0001_0000);
    bop(OP_BCD_SUBTRACT_DOUBLE, 32'h1);
    bop(OP_BCD_SUBTRACT_WORD, 32'h9999);
    bop(OP_LOAD, 32'h12);
    bop(OP_BCD_MULTIPLY_WORD, 32'h3);
    bop(OP_BCD_MULTIPLY_WORD, 32'h9999);
    bop(OP_BCD_MULTIPLY_WORD, 32'h0);
    bad(OP_BCD_SUBTRACT_WORD, 32'h00a1, 1'b0, 9'h001, 9'h131);
    bad(OP_BCD_SUBTRACT_DOUBLE, 32'hb000_0000, 1'b0, 9'h001, 9'h131);
    bad(OP_BCD_MULTIPLY_WORD, 32'h1, 1'b1, 9'h010, 9'h130);
    bad(OP_LOAD, 32'h1234, 1'b1, 9'h010, 9'h130);
    bad(brsma_op_e'(3'h6), 32'h1, 1'b0, 9'h0, 9'h0);
    for (int i = 0; i < 12; i++) begin
      seed = nxt_rnd(seed);
      bop(OP_LOAD, i2b({seed, nxt_rnd(seed)}));
      bop(OP_BCD_SUBTRACT_WORD, i2b(seed % DEC4));
      bop(OP_BCD_MULTIPLY_WORD, i2b(nxt_rnd(seed) % DEC4));
      bop(OP_BCD_SUBTRACT_DOUBLE, i2b({nxt_rnd(seed), seed}));
    end
    fork
      begin
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
      end
      bop(OP_LOAD, 32'h4321);
    join
    for (int i = 0; i < 13; i++) begin
      if (rows[i].c == OP_LOAD) bop(OP_LOAD, rows[i].v);
      else run(rows[i].c, rows[i].v, 1'b0, rows[i].r, rows[i].f, rows[i].m);
    end
    bad(OP_REAL_ADD, 32'h3f80_0000, 1'b1, 9'h010, 9'h130);
    i_seq.idle(1);
    for (int i = 0; i < 100 && q.size() != 0; i++) @(posedge clk);
    if (q.size() != 0) chk("pending results", 32'(q.size()), 32'h0);
    give_verdict();
  end
endmodule : bcd_real_subtract_multiply_alu_tb
